// File: bba_core.sv
// Sequencer for add, add-with-carry, AND, bit AND and bit compare
`timescale 1ns/1ps
`default_nettype none
module bba_core (
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                issue,
  input  wire bba_pkg::bba_insn_s  insn,
  input  wire logic [3:0]          wrk_base,
  input  wire bba_pkg::bba_flags_s flags_in,
  input  wire logic [7:0]          rf_rdata,
  output logic                     busy,
  output logic                     done,
  output logic                     bad_op,
  output logic [7:0]               rf_raddr,
  output logic                     rf_we,
  output logic [7:0]               rf_waddr,
  output logic [7:0]               rf_wdata,
  output logic                     flags_we,
  output bba_pkg::bba_flags_s      flags_out,
  output logic [1:0]               op_len
);
  import bba_pkg::*;

  function automatic logic [7:0] wreg(input logic [3:0] base,
                                      input logic [3:0] nib);
    wreg = {base, nib};
  endfunction : wreg

  // Decode of the instruction at issue
  wire [3:0]  opc_hi   = insn.opc[7:4];
  wire [3:0]  opc_lo   = insn.opc[3:0];
  wire        is_band  = (insn.opc == OPC_BAND);
  wire        is_bcmp  = (insn.opc == OPC_BCMP);
  wire        is_bit   = is_band || is_bcmp;
  wire        form_ok  = (opc_lo >= FORM_RR) && (opc_lo <= FORM_IM);
  wire        hi_ok    = (opc_hi == OPH_ADD) || (opc_hi == OPH_ADC)
                         || (opc_hi == OPH_AND);
  wire        sel_bit  = insn.b2[B2_SEL];
  wire [2:0]  bit_dec  = insn.b2[B2_BIT_HI:B2_BIT_LO];
  wire [3:0]  nib_hi   = insn.b2[B2_REG_HI:B2_REG_LO];
  wire        dec_ok   = is_band || (is_bcmp && !sel_bit)
                         || (form_ok && hi_ok && !is_bit);
  wire        dec_ind  = !is_bit && ((opc_lo == FORM_RIR)
                         || (opc_lo == FORM_FIR));
  wire        dec_imm  = !is_bit && (opc_lo == FORM_IM);
  wire        short_f  = !is_bit && (opc_lo == FORM_RR);
  wire        two_byte = !is_bit && ((opc_lo == FORM_RR)
                         || (opc_lo == FORM_RIR));
  wire [3:0]  dec_cyc  = short_f ? CYC_SHORT : CYC_LONG;
  wire [1:0]  dec_len  = two_byte ? LEN_SHORT : LEN_LONG;
  wire        accept   = issue && !busy && dec_ok;

  bba_op_e    dec_op;
  logic [7:0] dec_src;
  logic [7:0] dec_dst;

  always_comb begin
    dec_op  = BBA_OP_ADD;
    dec_src = 8'h00;
    dec_dst = 8'h00;
    if (is_band) begin
      dec_op = BBA_OP_BAND;
    end else if (is_bcmp) begin
      dec_op = BBA_OP_BCMP;
    end else if (opc_hi == OPH_ADC) begin
      dec_op = BBA_OP_ADC;
    end else if (opc_hi == OPH_AND) begin
      dec_op = BBA_OP_AND;
    end else begin
      dec_op = BBA_OP_ADD;
    end
    if (is_bit) begin
      // Form select 1 swaps roles: working reg is the source
      if (sel_bit) begin
        dec_src = wreg(wrk_base, nib_hi);
        dec_dst = insn.b3;
      end else begin
        dec_dst = wreg(wrk_base, nib_hi);
        dec_src = insn.b3;
      end
    end else begin
      case (opc_lo)
        FORM_RR, FORM_RIR: begin
          dec_dst = wreg(wrk_base, nib_hi);
          dec_src = wreg(wrk_base, insn.b2[3:0]);
        end
        FORM_FR, FORM_FIR: begin
          dec_src = insn.b2;
          dec_dst = insn.b3;
        end
        FORM_IM: begin
          dec_dst = insn.b2;
          dec_src = insn.b3;
        end
        default: begin
          dec_dst = 8'h00;
          dec_src = 8'h00;
        end
      endcase
    end
  end

  bba_state_e state;
  bba_state_e next_state;
  bba_op_e    op_q;
  logic [7:0] src_addr;
  logic [7:0] dst_addr;
  logic [7:0] src_val;
  logic [7:0] dst_q;
  logic [2:0] bit_q;
  logic       sel_q;
  logic       ind_q;
  logic [3:0] cyc_q;
  logic [3:0] cnt;
  logic [7:0] res_q;
  logic       wr_q;
  bba_flags_s fin_q;
  bba_flags_s alu_flags;
  logic [7:0] alu_res;
  logic       alu_wr;

  wire last = (state == ST_WAIT) && (cnt == cyc_q - 4'h1);

  bba_alu u_alu (
    .op        (op_q),
    .dst       (rf_rdata),
    .src       (src_val),
    .bit_idx   (bit_q),
    .sel       (sel_q),
    .flags_in  (flags_in),
    .res       (alu_res),
    .flags_out (alu_flags),
    .wr_dst    (alu_wr)
  );

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:  if (accept) next_state = dec_imm ? ST_DST : ST_FETCH;
      ST_FETCH: next_state = ind_q ? ST_DEREF : ST_DST;
      ST_DEREF: next_state = ST_DST;
      ST_DST:   next_state = ST_WAIT;
      ST_WAIT:  if (last) next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  // In FETCH an indirect form reads the pointer, else the source
  assign rf_raddr = (state == ST_FETCH) ? src_addr :
                    (state == ST_DEREF) ? src_addr :
                    (state == ST_DST)   ? dst_addr : 8'h00;
  assign busy     = (state != ST_IDLE);
  assign done     = last;
  assign rf_we    = last && wr_q;
  assign flags_we = last;
  assign bad_op   = issue && !busy && !dec_ok;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cnt   <= 4'h0;
    end else begin
      state <= next_state;
      cnt   <= (state == ST_IDLE) ? 4'h1 : cnt + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_q     <= BBA_OP_ADD;
      src_addr <= 8'h00;
      dst_addr <= 8'h00;
      bit_q    <= 3'h0;
      sel_q    <= 1'b0;
      ind_q    <= 1'b0;
      cyc_q    <= CYC_SHORT;
      op_len   <= LEN_SHORT;
    end else if (accept) begin
      op_q     <= dec_op;
      src_addr <= dec_src;
      dst_addr <= dec_dst;
      bit_q    <= bit_dec;
      sel_q    <= sel_bit;
      ind_q    <= dec_ind;
      cyc_q    <= dec_cyc;
      op_len   <= dec_len;
    end else if (state == ST_FETCH && ind_q) begin
      src_addr <= rf_rdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_val <= 8'h00;
    end else if (accept && dec_imm) begin
      src_val <= insn.b3;
    end else if ((state == ST_FETCH && !ind_q) || state == ST_DEREF) begin
      src_val <= rf_rdata;
    end
  end

  // Result held until the write cycle so the port data is registered
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      res_q <= 8'h00;
      wr_q  <= 1'b0;
      dst_q <= 8'h00;
      fin_q <= '0;
    end else if (state == ST_DST) begin
      res_q <= alu_res;
      wr_q  <= alu_wr;
      dst_q <= rf_rdata;
      fin_q <= flags_in;
    end
  end

  assign rf_waddr  = dst_addr;
  bba_flags_s alu_q;
  assign rf_wdata  = res_q;
  assign flags_out = alu_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) alu_q <= '0;
    else if (state == ST_DST) alu_q <= alu_flags;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_short_done: assert property (
    accept && dec_cyc == CYC_SHORT |-> ##3 done)
    else $error("short form did not finish in four cycles");
  a_long_done: assert property (
    accept && dec_cyc == CYC_LONG |-> !done [*5] ##1 done)
    else $error("long form did not finish in six cycles");
  a_add_sum: assert property (
    done && (op_q == BBA_OP_ADD || op_q == BBA_OP_ADC) |->
    {flags_out.c, rf_wdata} == {1'b0, dst_q} + {1'b0, src_val}
      + {8'h00, (op_q == BBA_OP_ADC) & fin_q.c})
    else $error("add sum or carry wrong");
  a_add_ovf: assert property (
    done && op_q == BBA_OP_ADD |-> flags_out.v ==
    ((dst_q[7] == src_val[7]) && (rf_wdata[7] != dst_q[7])) && !flags_out.d)
    else $error("add overflow flag wrong");
  a_and_keep: assert property (
    done && op_q == BBA_OP_AND |-> rf_wdata == (dst_q & src_val)
    && flags_out.c == fin_q.c && flags_out.h == fin_q.h && !flags_out.v)
    else $error("AND result or kept flags wrong");
  a_bit_single: assert property (
    done && op_q == BBA_OP_BAND |-> $onehot0(rf_wdata ^ dst_q)
    && flags_out.z == !rf_wdata[sel_q ? bit_q : 3'h0])
    else $error("bit AND touched more than one bit");
  a_cmp_nowrite: assert property (
    done && op_q == BBA_OP_BCMP |-> !rf_we && !flags_out.s
    && flags_out.z == (dst_q[0] == src_val[bit_q]))
    else $error("bit compare wrote or flagged wrongly");
  a_ind_fetch: assert property (
    state == ST_FETCH && ind_q |=> state == ST_DEREF
    && rf_raddr == $past(rf_rdata))
    else $error("indirect operand not fetched through pointer");
  // Half-carry rebuilt from bit 4 so it does not mirror the adder
  a_add_half: assert property (
    done && (op_q == BBA_OP_ADD || op_q == BBA_OP_ADC) |->
    flags_out.h == (rf_wdata[4] ^ dst_q[4] ^ src_val[4]) && !flags_out.d)
    else $error("add half-carry or decimal flag wrong");
  a_add_zero_sign: assert property (
    done && (op_q == BBA_OP_ADD || op_q == BBA_OP_ADC) |->
    flags_out.z == (rf_wdata == 8'h00) && flags_out.s == rf_wdata[7])
    else $error("add zero or sign flag wrong");
  a_band_keep: assert property (
    done && op_q == BBA_OP_BAND |-> !flags_out.s && flags_out.c == fin_q.c
    && flags_out.d == fin_q.d && flags_out.h == fin_q.h)
    else $error("bit AND changed kept flags");
  a_cmp_keep: assert property (
    done && op_q == BBA_OP_BCMP |-> flags_out.c == fin_q.c
    && flags_out.d == fin_q.d && flags_out.h == fin_q.h)
    else $error("bit compare changed kept flags");
  a_imm_src: assert property (
    accept && dec_imm |=> src_val == $past(insn.b3))
    else $error("immediate operand not taken from byte three");
  a_bad_ignored: assert property (
    bad_op |=> !busy)
    else $error("undecoded opcode was started");
endmodule : bba_core
`default_nettype wire

// File: bba_pkg.sv
// Shared constants and types for the byte and bit ALU datapath
package bba_pkg;

  // Opcode bases (low nibble selects the addressing form) and the full bit-op opcodes
  localparam logic [3:0] OPH_ADD  = 4'h0;
  localparam logic [3:0] OPH_ADC  = 4'h1;
  localparam logic [3:0] OPH_AND  = 4'h5;
  localparam logic [7:0] OPC_BAND = 8'h67;
  localparam logic [7:0] OPC_BCMP = 8'h17;

  // Addressing forms (opcode low nibble)
  localparam logic [3:0] FORM_RR   = 4'h2;
  localparam logic [3:0] FORM_RIR  = 4'h3;
  localparam logic [3:0] FORM_FR   = 4'h4;
  localparam logic [3:0] FORM_FIR  = 4'h5;
  localparam logic [3:0] FORM_IM   = 4'h6;

  // Cycle counts and instruction lengths
  localparam logic [3:0] CYC_SHORT = 4'h4;
  localparam logic [3:0] CYC_LONG  = 4'h6;
  localparam logic [1:0] LEN_SHORT = 2'h2;
  localparam logic [1:0] LEN_LONG  = 2'h3;

  // Second-byte fields of the single-bit forms
  localparam int B2_REG_HI = 7;
  localparam int B2_REG_LO = 4;
  localparam int B2_BIT_HI = 3;
  localparam int B2_BIT_LO = 1;
  localparam int B2_SEL    = 0;

  typedef enum logic [4:0] {
    BBA_OP_ADD  = 5'b00001,
    BBA_OP_ADC  = 5'b00010,
    BBA_OP_AND  = 5'b00100,
    BBA_OP_BAND = 5'b01000,
    BBA_OP_BCMP = 5'b10000
  } bba_op_e;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_FETCH = 5'b00010,
    ST_DEREF = 5'b00100,
    ST_DST   = 5'b01000,
    ST_WAIT  = 5'b10000
  } bba_state_e;

  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
    logic d;
    logic h;
  } bba_flags_s;

  typedef struct packed {
    logic [7:0] opc;
    logic [7:0] b2;
    logic [7:0] b3;
  } bba_insn_s;

endpackage : bba_pkg

// File: bba_alu.sv
// Combinational result and flag logic for the five operations
`timescale 1ns/1ps
`default_nettype none
module bba_alu (
  input  wire bba_pkg::bba_op_e   op,
  input  wire logic [7:0]         dst,
  input  wire logic [7:0]         src,
  input  wire logic [2:0]         bit_idx,
  input  wire logic               sel,
  input  wire bba_pkg::bba_flags_s flags_in,
  output logic [7:0]              res,
  output bba_pkg::bba_flags_s     flags_out,
  output logic                    wr_dst
);
  import bba_pkg::*;

  logic       cin;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic       bit_and;
  logic       bit_eq;

  assign cin     = (op == BBA_OP_ADC) ? flags_in.c : 1'b0;
  assign sum9    = {1'b0, dst} + {1'b0, src} + {8'h00, cin};
  assign nib5    = {1'b0, dst[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
  assign bit_and = sel ? (dst[bit_idx] & src[0])
                       : (dst[0] & src[bit_idx]);
  assign bit_eq  = (dst[0] == src[bit_idx]);

  always_comb begin
    res       = dst;
    flags_out = flags_in;
    wr_dst    = 1'b1;
    case (op)
      BBA_OP_ADD, BBA_OP_ADC: begin
        res         = sum9[7:0];
        flags_out.c = sum9[8];
        flags_out.z = (sum9[7:0] == 8'h00);
        flags_out.s = sum9[7];
        flags_out.v = (dst[7] == src[7]) && (sum9[7] != dst[7]);
        flags_out.d = 1'b0;
        flags_out.h = nib5[4];
      end
      BBA_OP_AND: begin
        res         = dst & src;
        flags_out.z = ((dst & src) == 8'h00);
        flags_out.s = dst[7] & src[7];
        flags_out.v = 1'b0;
      end
      BBA_OP_BAND: begin
        // Only the addressed bit moves; V is undefined and kept as is
        if (sel) begin
          res[bit_idx] = bit_and;
        end else begin
          res[0] = bit_and;
        end
        flags_out.z = ~bit_and;
        flags_out.s = 1'b0;
      end
      BBA_OP_BCMP: begin
        wr_dst      = 1'b0;
        flags_out.z = bit_eq;
        flags_out.s = 1'b0;
      end
      default: begin
        wr_dst = 1'b0;
      end
    endcase
  end
endmodule : bba_alu
`default_nettype wire

// File: bba_core_bench.sv
// Self-checking bench for the byte and bit ALU sequencer
`timescale 1ns/1ps
`default_nettype none
module bba_core_bench;
  import bba_pkg::*;
  logic       sys_clk;
  logic       rst_n;
  logic       issue;
  bba_insn_s  insn;
  logic [3:0] wrk_base;
  bba_flags_s flags_in;
  logic [7:0] rf_rdata;
  logic       busy;
  logic       done;
  logic       bad_op;
  logic [7:0] rf_raddr;
  logic       rf_we;
  logic [7:0] rf_waddr;
  logic [7:0] rf_wdata;
  logic       flags_we;
  bba_flags_s flags_out;
  logic [1:0] op_len;
  logic [7:0] rf [256];
  int         errors;
  int         cmp_count;

  bba_core u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .issue(issue), .insn(insn),
    .wrk_base(wrk_base), .flags_in(flags_in), .rf_rdata(rf_rdata),
    .busy(busy), .done(done), .bad_op(bad_op), .rf_raddr(rf_raddr),
    .rf_we(rf_we), .rf_waddr(rf_waddr), .rf_wdata(rf_wdata),
    .flags_we(flags_we), .flags_out(flags_out), .op_len(op_len)
  );

  // Register file answers in the same cycle, as the core expects
  assign rf_rdata = rf[rf_raddr];
  always @(posedge sys_clk) begin
    if (rf_we === 1'b1) rf[rf_waddr] <= rf_wdata;
  end
  always #25 sys_clk = ~sys_clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize;
    $display("comparisons=%0d mismatches=%0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  // One instruction: issue, wait for done, check count, write and flags
  task automatic do_op(input logic [7:0] opc, input logic [7:0] b2,
                       input logic [7:0] b3, input bba_flags_s fl,
                       input logic [7:0] ea, input logic [7:0] ed,
                       input bba_flags_s ef);
    int   n;
    logic we;
    we = (opc != OPC_BCMP);
    @(negedge sys_clk);
    issue = 1'b1;
    insn = {opc, b2, b3};
    flags_in = fl;
    @(negedge sys_clk);
    issue = 1'b0;
    n = 1;
    while (done !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    chk(8'(n), (opc[3:0] == FORM_RR) ? 8'h03 : 8'h05);
    chk({7'h0, rf_we}, {7'h0, we});
    chk({7'h0, flags_we}, 8'h01);
    chk({2'h0, flags_out}, {2'h0, ef});
    if (we) begin
      chk(rf_waddr, ea);
      chk(rf_wdata, ed);
    end
    chk({6'h0, op_len}, (opc[3:0] < 4'h4) ? 8'h02 : 8'h03);
    @(negedge sys_clk);
    chk({7'h0, busy}, 8'h00);
  endtask : do_op

  task automatic bad(input logic [7:0] opc, input logic [7:0] b2);
    @(negedge sys_clk);
    issue = 1'b1;
    insn = {opc, b2, 8'h00};
    #1;
    chk({7'h0, bad_op}, 8'h01);
    @(negedge sys_clk);
    issue = 1'b0;
    chk({7'h0, busy}, 8'h00);
  endtask : bad

  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    issue = 1'b0;
    insn = '0;
    wrk_base = 4'h3;
    flags_in = '0;
    errors = 0;
    cmp_count = 0;
    // Inverted contents make direct and indirect fetches differ
    for (int i = 0; i < 256; i++) rf[i] = ~i[7:0];
    rf[8'h33] = 8'h80;
    rf[8'h34] = 8'h80;
    rf[8'h35] = 8'h7f;
    rf[8'h36] = 8'h00;
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    chk({7'h0, busy}, 8'h00);
    chk({6'h0, op_len}, 8'h02);
    do_op(8'h12, 8'h12, 8'h00, 6'h20, 8'h31, 8'h9c, 6'h29);
    do_op(8'h02, 8'h34, 8'h00, 6'h02, 8'h33, 8'h00, 6'h34);
    do_op(8'h12, 8'h56, 8'h00, 6'h20, 8'h35, 8'h80, 6'h0d);
    do_op(8'h03, 8'h87, 8'h00, 6'h00, 8'h38, 8'hfe, 6'h08);
    do_op(8'h13, 8'h97, 8'h00, 6'h20, 8'h39, 8'hfe, 6'h08);
    do_op(8'h04, 8'h50, 8'h51, 6'h00, 8'h51, 8'h5d, 6'h25);
    do_op(8'h14, 8'h52, 8'h53, 6'h00, 8'h53, 8'h59, 6'h25);
    do_op(8'h05, 8'h54, 8'h55, 6'h00, 8'h55, 8'hfe, 6'h08);
    do_op(8'h15, 8'h56, 8'h57, 6'h20, 8'h57, 8'hff, 6'h08);
    do_op(8'h06, 8'h58, 8'h01, 6'h00, 8'h58, 8'ha8, 6'h08);
    do_op(8'h16, 8'h59, 8'h5a, 6'h20, 8'h59, 8'h01, 6'h21);
    do_op(8'h52, 8'hab, 8'h00, 6'h3f, 8'h3a, 8'hc4, 6'h2b);
    do_op(8'h53, 8'hcd, 8'h00, 6'h3f, 8'h3c, 8'h01, 6'h23);
    do_op(8'h54, 8'h5b, 8'h5c, 6'h3f, 8'h5c, 8'ha0, 6'h2b);
    do_op(8'h55, 8'h5d, 8'h5e, 6'h3f, 8'h5e, 8'h01, 6'h23);
    do_op(8'h56, 8'h5f, 8'h5f, 6'h3f, 8'h5f, 8'h00, 6'h33);
    do_op(8'h67, 8'hea, 8'h60, 6'h3f, 8'h3e, 8'hc0, 6'h37);
    do_op(8'h67, 8'h0f, 8'h61, 6'h3f, 8'h61, 8'h9e, 6'h27);
    do_op(8'h67, 8'hff, 8'h62, 6'h3f, 8'h62, 8'h1d, 6'h37);
    do_op(8'h17, 8'h06, 8'h63, 6'h3f, 8'h00, 8'h00, 6'h37);
    do_op(8'h17, 8'h00, 8'h63, 6'h00, 8'h00, 8'h00, 6'h00);
    bad(8'h17, 8'h01);
    bad(8'h07, 8'h00);
    chk(rf[8'h32], 8'hcd);
    chk(rf[8'h63], 8'h9c);
    summarize();
  end

  // Whole run is some 150 cycles; this bound is far beyond it
  initial begin
    repeat (3000) @(posedge sys_clk);
    errors++;
    summarize();
  end
endmodule : bba_core_bench
`default_nettype wire
